// [include/xcr_pkg.sv]
package xcr_pkg;

  localparam int unsigned N_PORTS        = 64;
  localparam int unsigned N_LINKS        = 3;
  localparam int unsigned N_XPT_IN       = 256;
  localparam int unsigned SRC_W          = 8;
  localparam int unsigned MAX_CHASSIS    = 4;

  localparam logic [11:0] OFF_MODE_LO    = 12'h000;
  localparam logic [11:0] OFF_MODE_HI    = 12'h004;
  localparam logic [11:0] OFF_TXEN_LO    = 12'h008;
  localparam logic [11:0] OFF_TXEN_HI    = 12'h00c;
  localparam logic [11:0] OFF_LOCK       = 12'h010;
  localparam logic [11:0] OFF_ACT_LO     = 12'h014;
  localparam logic [11:0] OFF_ACT_HI     = 12'h018;
  localparam logic [11:0] OFF_XPT_BASE   = 12'h400;
  localparam logic [11:0] OFF_XPT_LAST   = 12'h4fc;

  localparam int unsigned XPT_SRC_LSB    = 0;
  localparam int unsigned XPT_ON_BIT     = 8;
  localparam logic [8:0]  XPT_RST        = 9'h000;
  localparam logic [63:0] MODE_RST       = 64'h0000000000000000;
  localparam logic [63:0] TXEN_RST       = 64'h0000000000000000;

  localparam logic [7:0]  LINK_SYNC      = 8'ha5;
  localparam int unsigned LINK_SYNC_W    = 8;
  localparam logic        IDLE_LEVEL     = 1'b1;

  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned LAMP_TICK_NS   = 1000000;
  localparam int unsigned LAMP_TICK_CYC  = LAMP_TICK_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  ACT_HOLD_TICKS = 3'h4;
  localparam int unsigned LINK_BIT_DIV   = 4;

  typedef struct packed {
    logic ct_green;
    logic rx_yellow;
    logic tx_red;
    logic tx_green;
  } xcr_lamp_type;

endpackage : xcr_pkg

// [hw/xcr_xlink.sv]
`timescale 1ns/1ns
`default_nettype none

module xcr_xlink #(
  parameter int unsigned NB = 64
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          bit_en,
  input  wire logic [NB-1:0] tx_data,
  output logic               ser_tx,
  input  wire logic          ser_rx,
  output logic [NB-1:0]      rx_data,
  output logic               locked
);

  localparam int unsigned SW = xcr_pkg::LINK_SYNC_W;
  localparam int unsigned FL = SW + NB;
  localparam int unsigned CW = $clog2(FL);

  typedef enum {HUNT, DATA, CHECK} xcr_rx_state_type;

  logic [FL-1:0]         frame_r;
  logic [$clog2(FL)-1:0] tcnt_r;
  logic [SW-1:0]         hist_r;
  logic [SW-1:0]         hist_nxt;
  logic [NB-1:0]         dsr_r;
  logic [$clog2(FL)-1:0] rcnt_r;
  xcr_rx_state_type      rst_r;

  assign hist_nxt = {hist_r[SW-2:0], ser_rx};

  // Frame is sync word then sampled local inputs, sent msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= '0;
      tcnt_r  <= '0;
      ser_tx  <= xcr_pkg::IDLE_LEVEL;
    end else if (bit_en) begin
      ser_tx <= frame_r[FL-1];
      if (tcnt_r == CW'(FL - 1)) begin
        tcnt_r  <= '0;
        frame_r <= {xcr_pkg::LINK_SYNC, tx_data};
      end else begin
        tcnt_r  <= tcnt_r + 1'b1;
        frame_r <= {frame_r[FL-2:0], 1'b0};
      end
    end
  end

  // Receive: hunt for sync, take a block, confirm next sync before locking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r  <= '0;
      dsr_r   <= '0;
      rcnt_r  <= '0;
      rst_r   <= HUNT;
      rx_data <= '0;
      locked  <= 1'b0;
    end else if (bit_en) begin
      hist_r <= hist_nxt;
      case (rst_r)
        HUNT: begin
          rcnt_r <= '0;
          if (hist_nxt == xcr_pkg::LINK_SYNC) begin
            rst_r <= DATA;
          end
        end
        DATA: begin
          dsr_r <= {dsr_r[NB-2:0], ser_rx};
          if (rcnt_r == CW'(NB - 1)) begin
            rcnt_r <= '0;
            rst_r  <= CHECK;
          end else begin
            rcnt_r <= rcnt_r + 1'b1;
          end
        end
        CHECK: begin
          if (rcnt_r == CW'(SW - 1)) begin
            rcnt_r <= '0;
            if (hist_nxt == xcr_pkg::LINK_SYNC) begin
              rx_data <= dsr_r;
              locked  <= 1'b1;
              rst_r   <= DATA;
            end else begin
              locked <= 1'b0;
              rst_r  <= HUNT;
            end
          end else begin
            rcnt_r <= rcnt_r + 1'b1;
          end
        end
        default: rst_r <= HUNT;
      endcase
    end
  end

endmodule : xcr_xlink

`default_nettype wire

// [hw/xcr_router.sv]
// Notes on behaviour
// - Sixty-four bidirectional ports, each with one receive and one transmit signal.
// - Chassis link in groups of 64 ports, at most 256 ports total.
// - Crosspoint offers 256 inputs, local plus expansion, to each of 64 outputs.
// - Per port, control picks which line receives and which transmits.
// - After start-up each port is tributary: line A receives, line B transmits.
// - Control may swap a port's lines anytime; port then runs controller mode.
// - Transmit drivers stay disabled after start-up until enabled per port.
// - Controller lamp green in controller mode, dark in tributary mode.
// - Receive lamp yellow on transitions on the selected receive line.
// - Transmit lamp red when output low, green when high.
// - Disabled transmitter keeps its transmit lamp off.
// - Each port's selected receive signal feeds its own crosspoint input.
// - Source reaches destination only once its crosspoint is taken on.
// - Crosspoint output drives whichever line the port assigns to transmit.
// - Three expansion transceivers, each a serial link to another chassis.
// - Expansion transmit samples all local inputs, adds sync, serialises.
// - Expansion receive deserialises remote block onto a fixed input range.
// - Per-link frame lock shown; only then are those inputs usable.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module xcr_router #(
  parameter int unsigned NP       = xcr_pkg::N_PORTS,
  parameter int unsigned NL       = xcr_pkg::N_LINKS,
  parameter int unsigned TICK_CYC = xcr_pkg::LAMP_TICK_CYC,
  parameter int unsigned BIT_DIV  = xcr_pkg::LINK_BIT_DIV
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NP-1:0]              line_a_i,
  output logic [NP-1:0]                   line_a_o,
  output logic [NP-1:0]                   line_a_oe,
  input  wire logic [NP-1:0]              line_b_i,
  output logic [NP-1:0]                   line_b_o,
  output logic [NP-1:0]                   line_b_oe,
  output xcr_pkg::xcr_lamp_type [NP-1:0]  lamp,
  input  wire logic [NL-1:0]              xl_rx_i,
  output logic [NL-1:0]                   xl_tx_o,
  output logic [NL-1:0]                   frame_lock
);

  localparam int unsigned NI = xcr_pkg::N_XPT_IN;
  localparam int unsigned SW = xcr_pkg::SRC_W;

  typedef enum {
    SEL_MODE_LO,
    SEL_MODE_HI,
    SEL_TXEN_LO,
    SEL_TXEN_HI,
    SEL_LOCK,
    SEL_ACT_LO,
    SEL_ACT_HI,
    SEL_XPT,
    SEL_NONE
  } xcr_reg_sel_type;

  logic [NP-1:0]      mode_r;
  logic [NP-1:0]      txen_r;
  logic [8:0]         xpt_r [0:NP-1];
  logic [NP-1:0]      a_s1_r;
  logic [NP-1:0]      a_s2_r;
  logic [NP-1:0]      b_s1_r;
  logic [NP-1:0]      b_s2_r;
  logic [NL-1:0]      x_s1_r;
  logic [NL-1:0]      x_s2_r;
  logic [NP-1:0]      rx_sel;
  logic [NP-1:0]      rx_prev_r;
  logic [2:0]         act_cnt_r [0:NP-1];
  logic [NP-1:0]      act;
  logic [NP-1:0]      tx_data_r;
  logic [NP-1:0]      rx_blk [0:NL-1];
  logic [NI-1:0]      xpt_in;
  logic [31:0]        tick_cnt_r;
  logic               tick;
  logic [15:0]        bit_cnt_r;
  logic               bit_en;
  logic               wr_acc;
  logic               rd_setup;
  logic [31:0]        rd_nxt;
  logic               mapped;
  xcr_reg_sel_type    reg_sel;

  function automatic logic is_xpt(input logic [11:0] a);
    is_xpt = (a >= xcr_pkg::OFF_XPT_BASE) && (a <= xcr_pkg::OFF_XPT_LAST) && (a[1:0] == 2'b00);
  endfunction : is_xpt

  function automatic logic [5:0] xpt_idx(input logic [11:0] a);
    logic [11:0] d;
    d       = a - xcr_pkg::OFF_XPT_BASE;
    xpt_idx = d[7:2];
  endfunction : xpt_idx

  function automatic xcr_reg_sel_type reg_decode(input logic [11:0] a);
    if (a == xcr_pkg::OFF_MODE_LO) begin
      reg_decode = SEL_MODE_LO;
    end else if (a == xcr_pkg::OFF_MODE_HI) begin
      reg_decode = SEL_MODE_HI;
    end else if (a == xcr_pkg::OFF_TXEN_LO) begin
      reg_decode = SEL_TXEN_LO;
    end else if (a == xcr_pkg::OFF_TXEN_HI) begin
      reg_decode = SEL_TXEN_HI;
    end else if (a == xcr_pkg::OFF_LOCK) begin
      reg_decode = SEL_LOCK;
    end else if (a == xcr_pkg::OFF_ACT_LO) begin
      reg_decode = SEL_ACT_LO;
    end else if (a == xcr_pkg::OFF_ACT_HI) begin
      reg_decode = SEL_ACT_HI;
    end else if (is_xpt(a)) begin
      reg_decode = SEL_XPT;
    end else begin
      reg_decode = SEL_NONE;
    end
  endfunction : reg_decode

  // Line A pins pass two flip-flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_s1_r <= '0;
      a_s2_r <= '0;
    end else begin
      a_s1_r <= line_a_i;
      a_s2_r <= a_s1_r;
    end
  end

  // Line B pins pass two flip-flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_s1_r <= '0;
      b_s2_r <= '0;
    end else begin
      b_s1_r <= line_b_i;
      b_s2_r <= b_s1_r;
    end
  end

  // Expansion serial inputs pass two flip-flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_s1_r <= '0;
      x_s2_r <= '0;
    end else begin
      x_s1_r <= xl_rx_i;
      x_s2_r <= x_s1_r;
    end
  end

  // Receive line choice per port
  assign rx_sel = (mode_r & b_s2_r) | (~mode_r & a_s2_r);

  // Lamp tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      tick       <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick       <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick       <= 1'b0;
    end
  end

  // Expansion bit-rate divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= '0;
      bit_en    <= 1'b0;
    end else if (bit_cnt_r == 16'(BIT_DIV - 1)) begin
      bit_cnt_r <= '0;
      bit_en    <= 1'b1;
    end else begin
      bit_cnt_r <= bit_cnt_r + 16'h0001;
      bit_en    <= 1'b0;
    end
  end

  // Previous receive level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_r <= '0;
    end else begin
      rx_prev_r <= rx_sel;
    end
  end

  // Receive activity stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NP; i++) begin
        act_cnt_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (rx_sel[i] != rx_prev_r[i]) begin
          act_cnt_r[i] <= xcr_pkg::ACT_HOLD_TICKS;
        end else if (tick && act_cnt_r[i] != 3'h0) begin
          act_cnt_r[i] <= act_cnt_r[i] - 3'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      act[i] = (act_cnt_r[i] != 3'h0);
    end
  end

  // Expansion transceivers
  for (genvar l = 0; l < NL; l++) begin : g_link
    xcr_xlink #(
      .NB (NP)
    ) u_link (
      .pclk    (pclk),
      .presetn (presetn),
      .bit_en  (bit_en),
      .tx_data (rx_sel),
      .ser_tx  (xl_tx_o[l]),
      .ser_rx  (x_s2_r[l]),
      .rx_data (rx_blk[l]),
      .locked  (frame_lock[l])
    );
  end

  // Crosspoint inputs: local block first, then one block per linked chassis
  always_comb begin
    xpt_in = {NI{xcr_pkg::IDLE_LEVEL}};
    xpt_in[NP-1:0] = rx_sel;
    for (int l = 0; l < NL; l++) begin
      if (frame_lock[l]) begin
        xpt_in[(l+1)*NP +: NP] = rx_blk[l];
      end else begin
        xpt_in[(l+1)*NP +: NP] = {NP{xcr_pkg::IDLE_LEVEL}};
      end
    end
  end

  // Crosspoint outputs, one selection per output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_r <= '0;
    end else begin
      for (int o = 0; o < NP; o++) begin
        if (xpt_r[o][xcr_pkg::XPT_ON_BIT]) begin
          tx_data_r[o] <= xpt_in[xpt_r[o][SW-1:0]];
        end else begin
          tx_data_r[o] <= xcr_pkg::IDLE_LEVEL;
        end
      end
    end
  end

  // Transmit steering to the assigned line
  assign line_a_o  = tx_data_r;
  assign line_b_o  = tx_data_r;
  assign line_a_oe = txen_r & mode_r;
  assign line_b_oe = txen_r & ~mode_r;

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      lamp[i].ct_green  = mode_r[i];
      lamp[i].rx_yellow = act[i];
      lamp[i].tx_red    = txen_r[i] & ~tx_data_r[i];
      lamp[i].tx_green  = txen_r[i] & tx_data_r[i];
    end
  end

  // APB slave: zero wait, read data captured in setup phase
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign reg_sel  = reg_decode(paddr);

  always_comb begin
    mapped = 1'b1;
    rd_nxt = 32'h00000000;
    if (reg_sel == SEL_MODE_LO) begin
      rd_nxt = mode_r[31:0];
    end else if (reg_sel == SEL_MODE_HI) begin
      rd_nxt = mode_r[63:32];
    end else if (reg_sel == SEL_TXEN_LO) begin
      rd_nxt = txen_r[31:0];
    end else if (reg_sel == SEL_TXEN_HI) begin
      rd_nxt = txen_r[63:32];
    end else if (reg_sel == SEL_LOCK) begin
      rd_nxt[NL-1:0] = frame_lock;
    end else if (reg_sel == SEL_ACT_LO) begin
      rd_nxt = act[31:0];
    end else if (reg_sel == SEL_ACT_HI) begin
      rd_nxt = act[63:32];
    end else if (reg_sel == SEL_XPT) begin
      rd_nxt[8:0] = xpt_r[xpt_idx(paddr)];
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_nxt;
    end
  end

  // Port mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= xcr_pkg::MODE_RST;
    end else if (wr_acc && reg_sel == SEL_MODE_LO) begin
      mode_r[31:0] <= pwdata;
    end else if (wr_acc && reg_sel == SEL_MODE_HI) begin
      mode_r[63:32] <= pwdata;
    end
  end

  // Transmit enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_r <= xcr_pkg::TXEN_RST;
    end else if (wr_acc && reg_sel == SEL_TXEN_LO) begin
      txen_r[31:0] <= pwdata;
    end else if (wr_acc && reg_sel == SEL_TXEN_HI) begin
      txen_r[63:32] <= pwdata;
    end
  end

  // Crosspoint take registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int o = 0; o < NP; o++) begin
        xpt_r[o] <= xcr_pkg::XPT_RST;
      end
    end else if (wr_acc && reg_sel == SEL_XPT) begin
      xpt_r[xpt_idx(paddr)] <= pwdata[8:0];
    end
  end

endmodule : xcr_router

`default_nettype wire

// [dv/xcr_router_properties.sv]
`timescale 1ns/1ns
`default_nettype none

module xcr_router_properties #(
  parameter int unsigned NP      = 64,
  parameter int unsigned NL      = 3,
  parameter int unsigned BIT_DIV = 4
) (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic [NP-1:0]                  line_a_i,
  input wire logic [NP-1:0]                  line_b_i,
  input wire logic [NP-1:0]                  line_a_o,
  input wire logic [NP-1:0]                  line_b_o,
  input wire logic [NP-1:0]                  line_a_oe,
  input wire logic [NP-1:0]                  line_b_oe,
  input wire xcr_pkg::xcr_lamp_type [NP-1:0] lamp,
  input wire logic [NL-1:0]                  frame_lock
);
  logic [NP-1:0] ct_v, rxy_v, txr_v, txg_v, a_q, b_q, ct_q, win;
  logic [NP-1:0] hist_r [6];
  logic [15:0]   cyc_r;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      ct_v[p]  = lamp[p].ct_green;
      rxy_v[p] = lamp[p].rx_yellow;
      txr_v[p] = lamp[p].tx_red;
      txg_v[p] = lamp[p].tx_green;
    end
  end

  // Recent changes on either line or on the port mode
  always_ff @(posedge pclk) begin
    a_q       <= line_a_i;
    b_q       <= line_b_i;
    ct_q      <= ct_v;
    hist_r[0] <= (line_a_i ^ a_q) | (line_b_i ^ b_q) | (ct_v ^ ct_q);
    for (int i = 1; i < 6; i++) begin
      hist_r[i] <= hist_r[i-1];
    end
  end

  always_comb begin
    win = (line_a_i ^ a_q) | (line_b_i ^ b_q) | (ct_v ^ ct_q);
    for (int i = 0; i < 6; i++) begin
      win = win | hist_r[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 16'h0000;
    end else if (cyc_r != 16'hffff) begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  reset_quiet_a: assert property ($rose(presetn) |-> (line_a_oe | line_b_oe) == '0 && frame_lock == '0)
    else $error("driver enabled or lock set after reset");
  idle_out_a: assert property ($rose(presetn) |=> line_a_o == '1)
    else $error("output not idle after reset");
  oe_exclusive_a: assert property ((line_a_oe & line_b_oe) == '0)
    else $error("both lines of a port driven");
  ct_lamp_a: assert property ((ct_v & line_b_oe) == '0 && (~ct_v & line_a_oe) == '0)
    else $error("controller lamp disagrees with driven line");
  tx_lamp_off_a: assert property (((txr_v | txg_v) & ~(line_a_oe | line_b_oe)) == '0)
    else $error("transmit lamp lit on disabled port");
  tx_colour_a: assert property (txg_v == ((line_a_oe | line_b_oe) & line_a_o)
                                && txr_v == ((line_a_oe | line_b_oe) & ~line_a_o))
    else $error("transmit lamp colour wrong");
  lines_same_a: assert property (line_a_o == line_b_o)
    else $error("line outputs differ");
  lock_wait_a: assert property (cyc_r < 16'(72 * BIT_DIV) |-> frame_lock == '0)
    else $error("lock before a full frame");
  rx_cause_a: assert property (((rxy_v & ~$past(rxy_v)) & ~win) == '0)
    else $error("activity lamp without line change");
endmodule : xcr_router_properties

bind xcr_router xcr_router_properties #(.NP(NP), .NL(NL), .BIT_DIV(BIT_DIV)) u_props (
  .pclk(pclk), .presetn(presetn), .line_a_i(line_a_i), .line_b_i(line_b_i), .line_a_o(line_a_o),
  .line_b_o(line_b_o), .line_a_oe(line_a_oe), .line_b_oe(line_b_oe), .lamp(lamp), .frame_lock(frame_lock));

`default_nettype wire

// [dv/xcr_far_side.sv]
`timescale 1ns/1ns
`default_nettype none

module xcr_far_side #(
  parameter int unsigned NP = 64,
  parameter int unsigned NL = 3
) (
  input wire logic [0:0]    pclk,
  input wire logic          presetn,
  input wire logic [NP-1:0] ext_a,
  input wire logic [NP-1:0] ext_b,
  input wire logic [NP-1:0] line_a_o,
  input wire logic [NP-1:0] line_a_oe,
  input wire logic [NP-1:0] line_b_o,
  input wire logic [NP-1:0] line_b_oe,
  output logic [NP-1:0]     line_a_i,
  output logic [NP-1:0]     line_b_i,
  input wire logic [NL-1:0] xl_tx_o,
  input wire logic [NL-1:0] cut,
  input wire logic [NL-1:0] slow,
  output logic [NL-1:0]     xl_rx_i
);
  logic [1:0]    noise_r;
  logic [NL-1:0] echo_r;

  // Wire level: the router wins where it drives, else the attached equipment
  assign line_a_i = (line_a_oe & line_a_o) | (~line_a_oe & ext_a);
  assign line_b_i = (line_b_oe & line_b_o) | (~line_b_oe & ext_b);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise_r <= 2'h0;
      echo_r  <= '1;
    end else begin
      noise_r <= noise_r + 2'h1;
      echo_r  <= xl_tx_o;
    end
  end

  // Remote chassis returns our frames, promptly or a cycle late; a broken link toggles
  assign xl_rx_i = (cut & {NL{noise_r[1]}}) | (~cut & slow & echo_r) | (~cut & ~slow & xl_tx_o);
endmodule : xcr_far_side

`default_nettype wire

// [dv/xcr_router_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module xcr_router_bench;
  localparam int unsigned NP = xcr_pkg::N_PORTS;
  localparam int unsigned NL = xcr_pkg::N_LINKS;
  logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]                    paddr;
  logic [31:0]                    pwdata, prdata, rd;
  logic [NP-1:0]                  line_a_i, line_a_o, line_a_oe, line_b_i, line_b_o, line_b_oe, ext_a, ext_b;
  logic [NL-1:0]                  xl_rx_i, xl_tx_o, frame_lock, cut;
  xcr_pkg::xcr_lamp_type [NP-1:0] lamp;
  int                             err_count, cmp_count, k;
  logic [11:0]                    regs [4] = '{xcr_pkg::OFF_MODE_LO, xcr_pkg::OFF_MODE_HI,
                                               xcr_pkg::OFF_TXEN_LO, xcr_pkg::OFF_TXEN_HI};

  xcr_router #(.TICK_CYC(4), .BIT_DIV(2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_a_i(line_a_i),
    .line_a_o(line_a_o), .line_a_oe(line_a_oe), .line_b_i(line_b_i), .line_b_o(line_b_o),
    .line_b_oe(line_b_oe), .lamp(lamp), .xl_rx_i(xl_rx_i), .xl_tx_o(xl_tx_o), .frame_lock(frame_lock));
  xcr_far_side #(.NP(NP), .NL(NL)) u_far (
    .pclk(pclk), .presetn(presetn), .ext_a(ext_a), .ext_b(ext_b), .line_a_o(line_a_o), .line_a_oe(line_a_oe),
    .line_b_o(line_b_o), .line_b_oe(line_b_oe), .line_a_i(line_a_i), .line_b_i(line_b_i),
    .xl_tx_o(xl_tx_o), .cut(cut), .slow(3'b100), .xl_rx_i(xl_rx_i));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task wait_out(input int o, input logic v);
    for (k = 0; k < 1500 && line_a_o[o] !== v; k++) @(posedge pclk);
    @(negedge pclk);
  endtask : wait_out

  task wait_lock(input logic [NL-1:0] v);
    for (k = 0; k < 1500 && frame_lock !== v; k++) @(posedge pclk);
    @(negedge pclk);
  endtask : wait_lock

  task link_out(input logic v);
    for (int l = 0; l < 3; l++) begin
      wait_out(10 + l, v);
      check(line_a_o[10 + l], v);
    end
  endtask : link_out

  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  function automatic logic [11:0] xa(input int o);
    return xcr_pkg::OFF_XPT_BASE + 12'(4 * o);
  endfunction : xa

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_a, ext_b, cut, presetn} = '0;
    {err_count, cmp_count} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    check(line_a_oe | line_b_oe, '0);
    check(line_a_o, '1);
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, regs[r], 32'h0);
      check(rd, 32'({xcr_pkg::TXEN_RST, xcr_pkg::MODE_RST} >> (32 * r)));
    end
    apb(1'b0, xa(63), 32'h0);
    check(rd, 32'(xcr_pkg::XPT_RST));
    apb(1'b0, 12'h100, 32'h0);
    check({err, rd}, 33'h100000000);
    $display("test reset done");
    apb(1'b1, xa(0), 32'h105);
    apb(1'b1, xa(1), 32'h105);
    settle(1);
    check(line_a_o[1:0], 2'b00);
    check(lamp[0], 4'h0);
    apb(1'b1, xcr_pkg::OFF_TXEN_LO, 32'h3);
    apb(1'b1, xcr_pkg::OFF_MODE_LO, 32'h1);
    settle(0);
    check({line_b_oe[1:0], line_a_oe[1:0]}, 4'b1001);
    check({lamp[1], lamp[0]}, 8'h2a);
    @(posedge pclk);
    ext_a[5] <= 1'b1;
    settle(3);
    check({line_a_o[1:0], lamp[0].tx_red, lamp[0].tx_green}, 4'b1101);
    apb(1'b1, xa(2), 32'h100);
    settle(1);
    check(line_a_o[2], 1'b0);
    @(posedge pclk);
    ext_b[0] <= 1'b1;
    settle(3);
    check(line_a_o[2], 1'b1);
    @(posedge pclk);
    ext_a[5] <= 1'b0;
    apb(1'b1, xcr_pkg::OFF_TXEN_LO, 32'h0);
    apb(1'b1, xa(0), 32'h005);
    apb(1'b0, xcr_pkg::OFF_MODE_LO, 32'h0);
    check(rd, 32'h1);
    settle(1);
    check({line_a_oe[0], lamp[0].tx_red, lamp[0].tx_green, line_a_o[1:0]}, 5'b00001);
    $display("test ports done");
    @(posedge pclk);
    ext_a[7] <= 1'b1;
    settle(4);
    check(lamp[7].rx_yellow, 1'b1);
    apb(1'b0, xcr_pkg::OFF_ACT_LO, 32'h0);
    check(rd[8:7], 2'b01);
    settle(40);
    check(lamp[7].rx_yellow, 1'b0);
    $display("test activity done");
    wait_lock(3'b111);
    check(frame_lock, 3'b111);
    apb(1'b0, xcr_pkg::OFF_LOCK, 32'h0);
    check(rd, 32'h7);
    for (int l = 0; l < 3; l++) begin
      apb(1'b1, xa(10 + l), 32'h100 + 32'(64 * (l + 1) + 5));
    end
    link_out(1'b0);
    @(posedge pclk);
    ext_a[5] <= 1'b1;
    link_out(1'b1);
    @(posedge pclk);
    ext_a[5] <= 1'b0;
    link_out(1'b0);
    @(posedge pclk);
    cut <= 3'b010;
    wait_lock(3'b101);
    settle(2);
    check({frame_lock, line_a_o[12:10]}, 6'b101010);
    @(posedge pclk);
    cut <= 3'b000;
    wait_lock(3'b111);
    wait_out(11, 1'b0);
    check({frame_lock, line_a_o[12:10]}, 6'b111000);
    $display("test links done");
    finish_test;
  end
endmodule : xcr_router_bench

`default_nettype wire
